// ==== rtl/icm_pkg.sv ====
// package: register map, field layouts and constants of the capture channel
package icm_pkg;

  // register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_CTRL1    = 5'h00;
  localparam logic [4:0] OFS_CTRL2    = 5'h04;
  localparam logic [4:0] OFS_BUF      = 5'h08;
  localparam logic [4:0] OFS_TIMER    = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h14;
  localparam logic [4:0] OFS_IRQ_CLR  = 5'h18;

  // reset values
  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [15:0] CTRL2_RESET = 16'h000D;

  // capture buffer depth
  localparam int          BUF_DEPTH   = 4;
  localparam int          BUF_AW      = 2;

  // prescaled edge counts
  localparam logic [3:0]  PRE_4TH     = 4'h3;
  localparam logic [3:0]  PRE_16TH    = 4'hF;

  // source select codes that stand for other capture channel timers
  localparam logic [4:0]  SRC_CAP_LO  = 5'h05;
  localparam logic [4:0]  SRC_CAP_HI  = 5'h08;
  // reserved source codes: 01001 01010 10100 10101 11101 11110 11111
  localparam logic [31:0] SRC_VALID   = 32'h1FCF_F9FF;

  // interrupt status bit positions
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_OVERFLOW = 1;
  localparam int IRQ_TRIGGER = 2;
  localparam int IRQ_WAKE    = 3;
  localparam int IRQ_W       = 4;

  typedef enum logic [2:0] {
    ICM_MODE_OFF     = 3'b000,
    ICM_MODE_FALL    = 3'b001,
    ICM_MODE_RISE    = 3'b010,
    ICM_MODE_BOTH    = 3'b011,
    ICM_MODE_RISE4   = 3'b100,
    ICM_MODE_RISE16  = 3'b101,
    ICM_MODE_RSVD    = 3'b110,
    ICM_MODE_WAKE    = 3'b111
  } icm_mode_t;

  // clock select codes
  localparam logic [2:0] CLK_PERIPH  = 3'b111;
  localparam logic [2:0] CLK_RSVD_A  = 3'b110;
  localparam logic [2:0] CLK_RSVD_B  = 3'b101;

  typedef struct packed {
    logic [2:0]  rsvd_hi;
    logic [2:0]  capture_clock_sel;
    logic [2:0]  rsvd_mid;
    logic [1:0]  captures_per_irq;
    logic        capture_overflow_flag;
    logic        buffer_not_empty_flag;
    logic [2:0]  capture_mode_sel;
  } icm_ctrl1_t;

  typedef struct packed {
    logic [6:0]  rsvd_hi;
    logic        cascade_pair_enable;
    logic        trigger_operation_sel;
    logic        timer_triggered_status;
    logic        rsvd_lo;
    logic [4:0]  sync_source_sel;
  } icm_ctrl2_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } icm_avl_req_t;

endpackage

// ==== rtl/icm_capture.sv ====
// input capture channel: mode select, trigger/sync timer, buffer and irq
//
// Notes on behaviour
// - mode 000 keeps the channel off, no captures at all
// - read-only overflow and buffer-not-empty flags follow the capture buffer
// - cascade bit joins odd and even channel into one 32-bit capture unit
// - trigger select 1: selected source event starts the capture timer
// - trigger select 0: selected source event synchronises the timer
// - triggered status reads 1 once the timer is triggered and counting
// - while triggered status is 0 the timer is held at zero
// - source event sets triggered status; software may read, set, clear it
// - five-bit source select field chooses the sync or trigger event
// - capture timer sources act one cycle after that timer rolls over
// - bits 15 to 9 and bit 5 of control two read as zero
// - two-bit field sets captures per interrupt, unused in modes 001, 111
// - clock select 111 is the core clock, 110 and 101 are reserved
// - source codes map to event inputs; reserved codes select nothing
`timescale 1ns/1ps

module icm_capture (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        CAP_IN,
  input  wire logic        SLEEP_IDLE,
  input  wire logic [4:0]  TIMER_TICK,
  input  wire logic [31:0] SYNC_EVENT,
  input  wire logic        PARTNER_CASCADE,
  output logic             CASCADE_EN,
  output logic             TIMER_ROLLOVER,
  output logic             CAPTURE_EVENT,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state, answer registered

  icm_pkg::icm_avl_req_t req;
  logic                  ack_q;
  logic [31:0]           rdata_q;
  logic                  acc;
  logic                  wr_acc;
  logic                  rd_acc;

  assign req.read      = AVS_READ;
  assign req.write     = AVS_WRITE;
  assign req.address   = AVS_ADDRESS;
  assign req.writedata = AVS_WRITEDATA;

  assign AVS_WAITREQUEST = (req.read | req.write) & ~ack_q;
  assign acc             = (req.read | req.write) & ack_q;
  assign wr_acc          = acc & req.write;
  assign rd_acc          = acc & req.read;
  assign AVS_READDATA    = rdata_q;

  wire sel_ctrl1 = req.address == icm_pkg::OFS_CTRL1;
  wire sel_ctrl2 = req.address == icm_pkg::OFS_CTRL2;
  wire sel_buf   = req.address == icm_pkg::OFS_BUF;
  wire sel_timer = req.address == icm_pkg::OFS_TIMER;
  wire sel_stat  = req.address == icm_pkg::OFS_IRQ_STAT;
  wire sel_en    = req.address == icm_pkg::OFS_IRQ_EN;
  wire sel_clr   = req.address == icm_pkg::OFS_IRQ_CLR;

  wire wr_ctrl1  = wr_acc & sel_ctrl1;
  wire wr_ctrl2  = wr_acc & sel_ctrl2;
  wire wr_en     = wr_acc & sel_en;
  wire wr_clr    = wr_acc & sel_clr;
  wire rd_buf    = rd_acc & sel_buf;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= AVS_WAITREQUEST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [2:0]  mode_q;
  logic [1:0]  per_irq_q;
  logic [2:0]  clk_sel_q;
  logic        cascade_q;
  logic        trig_op_q;
  logic        trig_stat_q;
  logic        trig_stat_d;
  logic [4:0]  src_sel_q;

  localparam int IRQ_WB = icm_pkg::IRQ_W;

  icm_pkg::icm_ctrl1_t wr1;
  icm_pkg::icm_ctrl2_t wr2;
  assign wr1 = AVS_WRITEDATA[15:0];
  assign wr2 = AVS_WRITEDATA[15:0];

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q    <= icm_pkg::CTRL1_RESET[2:0];
      per_irq_q <= icm_pkg::CTRL1_RESET[6:5];
      clk_sel_q <= icm_pkg::CTRL1_RESET[12:10];
    end else if (wr_ctrl1) begin
      mode_q    <= wr1.capture_mode_sel;
      per_irq_q <= wr1.captures_per_irq;
      clk_sel_q <= wr1.capture_clock_sel;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cascade_q <= icm_pkg::CTRL2_RESET[8];
      trig_op_q <= icm_pkg::CTRL2_RESET[7];
      src_sel_q <= icm_pkg::CTRL2_RESET[4:0];
    end else if (wr_ctrl2) begin
      cascade_q <= wr2.cascade_pair_enable;
      trig_op_q <= wr2.trigger_operation_sel;
      src_sel_q <= wr2.sync_source_sel;
    end
  end

  icm_pkg::icm_mode_t mode;
  assign mode = icm_pkg::icm_mode_t'(mode_q);

  ////////////////////////////////////////////////////////////////////////////
  // source select and trigger status

  logic        src_raw;
  logic        src_is_timer;
  logic        src_late_q;
  logic        src_evt;

  // reserved codes are masked out and select nothing
  assign src_raw = SYNC_EVENT[src_sel_q] & icm_pkg::SRC_VALID[src_sel_q];
  // a capture timer source acts the cycle after its rollover
  assign src_is_timer = (src_sel_q >= icm_pkg::SRC_CAP_LO) &
                        (src_sel_q <= icm_pkg::SRC_CAP_HI);
  assign src_evt = src_is_timer ? src_late_q : src_raw;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_late_q <= 1'b0;
    end else begin
      src_late_q <= src_raw & src_is_timer;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    trig_stat_d = trig_stat_q;
    if (wr_ctrl2) begin
      trig_stat_d = wr2.timer_triggered_status;
    end
    if (src_evt) begin
      trig_stat_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trig_stat_q <= icm_pkg::CTRL2_RESET[6];
    end else begin
      trig_stat_q <= trig_stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture timer

  logic        tick;
  logic        cascaded;
  logic [15:0] tmr_lo_q;
  logic [15:0] tmr_hi_q;
  logic        lo_wrap;
  logic        rollover;
  logic        sync_clr;

  always_comb begin
    unique case (clk_sel_q)
      icm_pkg::CLK_PERIPH: tick = 1'b1;
      icm_pkg::CLK_RSVD_A: tick = 1'b0;
      icm_pkg::CLK_RSVD_B: tick = 1'b0;
      default:             tick = TIMER_TICK[clk_sel_q];
    endcase
  end

  // the pair only cascades when both halves ask for it
  assign cascaded   = cascade_q & PARTNER_CASCADE;
  assign CASCADE_EN = cascade_q;
  assign lo_wrap    = tick & trig_stat_q & (tmr_lo_q == 16'hFFFF);
  assign rollover   = cascaded ? lo_wrap & (tmr_hi_q == 16'hFFFF) : lo_wrap;
  // in sync operation each source event restarts the count from zero
  assign sync_clr   = src_evt & ~trig_op_q;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tmr_lo_q <= 16'h0000;
      tmr_hi_q <= 16'h0000;
    end else if (!trig_stat_q || sync_clr) begin
      tmr_lo_q <= 16'h0000;
      tmr_hi_q <= 16'h0000;
    end else if (tick) begin
      tmr_lo_q <= tmr_lo_q + 16'h0001;
      if (cascaded && lo_wrap) begin
        tmr_hi_q <= tmr_hi_q + 16'h0001;
      end else if (!cascaded) begin
        tmr_hi_q <= 16'h0000;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      TIMER_ROLLOVER <= 1'b0;
    end else begin
      TIMER_ROLLOVER <= rollover;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and prescaler

  logic        cap_prev_q;
  logic        rise;
  logic        fall;
  logic [3:0]  pre_q;
  logic        cap_hit;
  logic        wake_hit;
  logic        active;

  assign rise   = CAP_IN & ~cap_prev_q;
  assign fall   = ~CAP_IN & cap_prev_q;
  assign active = (mode != icm_pkg::ICM_MODE_OFF) &
                  (mode != icm_pkg::ICM_MODE_RSVD);

  always_comb begin
    unique case (mode)
      icm_pkg::ICM_MODE_FALL:   cap_hit = fall;
      icm_pkg::ICM_MODE_RISE:   cap_hit = rise;
      icm_pkg::ICM_MODE_BOTH:   cap_hit = rise | fall;
      icm_pkg::ICM_MODE_RISE4:  cap_hit = rise &
                                (pre_q[1:0] == icm_pkg::PRE_4TH[1:0]);
      icm_pkg::ICM_MODE_RISE16: cap_hit = rise & (pre_q == icm_pkg::PRE_16TH);
      default:                  cap_hit = 1'b0;
    endcase
  end

  // mode 111 stores nothing, it only wakes the core
  assign wake_hit = (mode == icm_pkg::ICM_MODE_WAKE) & rise & SLEEP_IDLE;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap_prev_q <= 1'b0;
      pre_q      <= 4'h0;
    end else begin
      cap_prev_q <= CAP_IN;
      if (!active || wr_ctrl1) begin
        pre_q <= 4'h0;
      end else if (rise) begin
        pre_q <= pre_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture buffer

  logic [31:0]               buf_mem [icm_pkg::BUF_DEPTH];
  logic [icm_pkg::BUF_AW-1:0] wptr_q;
  logic [icm_pkg::BUF_AW-1:0] rptr_q;
  logic [icm_pkg::BUF_AW:0]   cnt_q;
  logic                      full;
  logic                      empty;
  logic                      push;
  logic                      pop;
  logic                      ovf_q;
  logic                      ovf_set;

  assign full    = cnt_q == 3'(icm_pkg::BUF_DEPTH);
  assign empty   = cnt_q == 3'h0;
  assign push    = cap_hit & ~full;
  assign pop     = rd_buf & ~empty;
  assign ovf_set = cap_hit & full;

  always_ff @(posedge CORE_CLK) begin
    if (push) begin
      buf_mem[wptr_q] <= {tmr_hi_q, tmr_lo_q};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else if (!active) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      wptr_q <= wptr_q + BUF_INC(push);
      rptr_q <= rptr_q + BUF_INC(pop);
      cnt_q  <= cnt_q + {2'b00, push} - {2'b00, pop};
    end
  end

  function automatic logic [icm_pkg::BUF_AW-1:0] BUF_INC(input logic b);
    BUF_INC = {{(icm_pkg::BUF_AW-1){1'b0}}, b};
  endfunction

  // overflow holds until the channel is switched off (mode 000) or set to mode 110
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovf_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q <= 1'b1;
    end else if (!active) begin
      ovf_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // captures per interrupt

  logic [1:0] ev_cnt_q;
  logic       cap_irq;
  logic       per_used;

  assign per_used = mode != icm_pkg::ICM_MODE_FALL;
  assign cap_irq  = push & (!per_used || (ev_cnt_q == per_irq_q));

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ev_cnt_q <= 2'h0;
    end else if (!active || wr_ctrl1 || cap_irq) begin
      ev_cnt_q <= 2'h0;
    end else if (push) begin
      ev_cnt_q <= ev_cnt_q + 2'h1;
    end
  end

  assign CAPTURE_EVENT = cap_irq;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and clear

  logic [IRQ_WB-1:0] ev_vec;
  logic [IRQ_WB-1:0] stat_q;
  logic [IRQ_WB-1:0] en_q;

  assign ev_vec[icm_pkg::IRQ_CAPTURE]  = cap_irq;
  assign ev_vec[icm_pkg::IRQ_OVERFLOW] = ovf_set;
  assign ev_vec[icm_pkg::IRQ_TRIGGER]  = src_evt;
  assign ev_vec[icm_pkg::IRQ_WAKE]     = wake_hit;

  for (genvar i = 0; i < IRQ_WB; i++) begin : g_stat
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        stat_q[i] <= 1'b0;
      end else if (ev_vec[i]) begin
        stat_q[i] <= 1'b1;
      end else if (wr_clr && AVS_WRITEDATA[i]) begin
        stat_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_q <= '0;
    end else if (wr_en) begin
      en_q <= AVS_WRITEDATA[IRQ_WB-1:0];
    end
  end

  assign IRQ = |(stat_q & en_q);

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [15:0] rd_ctrl1;
  logic [15:0] rd_ctrl2;
  logic [31:0] rd_buf_w;
  logic [31:0] rd_mux;

  assign rd_ctrl1 = {3'b000, clk_sel_q, 3'b000, per_irq_q,
                     ovf_q, ~empty, mode_q};
  assign rd_ctrl2 = {7'h00, cascade_q, trig_op_q, trig_stat_q,
                     1'b0, src_sel_q};
  assign rd_buf_w = empty ? 32'h0000_0000 :
                    cascaded ? buf_mem[rptr_q] :
                    {16'h0000, buf_mem[rptr_q][15:0]};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl1) begin
      rd_mux = {16'h0000, rd_ctrl1};
    end else if (sel_ctrl2) begin
      rd_mux = {16'h0000, rd_ctrl2};
    end else if (sel_buf) begin
      rd_mux = rd_buf_w;
    end else if (sel_timer) begin
      rd_mux = {tmr_hi_q, tmr_lo_q};
    end else if (sel_stat) begin
      rd_mux = {28'h0000000, stat_q};
    end else if (sel_en) begin
      rd_mux = {28'h0000000, en_q};
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

endmodule

// ==== sim/icm_capture_properties.sv ====
// checker: concurrent properties on the capture channel ports
`timescale 1ns/1ps

module icm_capture_properties (
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic [4:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        CAP_IN,
  input wire logic        CASCADE_EN,
  input wire logic        CAPTURE_EVENT,
  input wire logic        IRQ
);
  logic [2:0] mode_q;
  logic       wr_ok;
  logic       rd_ok;
  logic       req;

  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  assign req   = AVS_READ || AVS_WRITE;

  // shadow of the mode field, updated where the write takes effect
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q <= 3'h0;
    end else if (wr_ok && AVS_ADDRESS == icm_pkg::OFS_CTRL1) begin
      mode_q <= AVS_WRITEDATA[2:0];
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  //////////////////////////////////////////////////////////////////////////
  property p_one_wait;
    $rose(req) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endproperty
  property p_no_double;
    req && !AVS_WAITREQUEST |=> AVS_WAITREQUEST || !req;
  endproperty
  property p_cascade;
    wr_ok && AVS_ADDRESS == icm_pkg::OFS_CTRL2
      |=> CASCADE_EN == $past(AVS_WRITEDATA[8]);
  endproperty
  property p_rsvd_zero;
    rd_ok && AVS_ADDRESS == icm_pkg::OFS_CTRL2
      |-> AVS_READDATA[15:9] == 7'h00 && !AVS_READDATA[5];
  endproperty
  property p_off;
    mode_q == 3'h0 |-> !CAPTURE_EVENT;
  endproperty
  property p_wake;
    mode_q == 3'h7 |-> !CAPTURE_EVENT;
  endproperty
  property p_fall;
    mode_q == 3'h1 && $fell(CAP_IN) |-> ##[0:2] CAPTURE_EVENT;
  endproperty
  // pulses stay high long enough that the rise capture is already done
  property p_rise_only;
    mode_q == 3'h2 && $fell(CAP_IN) |-> !CAPTURE_EVENT [*3];
  endproperty

  a_one_wait:    assert property (p_one_wait)    else $error("wait state");
  a_no_double:   assert property (p_no_double)   else $error("double ack");
  a_cascade:     assert property (p_cascade)     else $error("cascade");
  a_rsvd_zero:   assert property (p_rsvd_zero)   else $error("rsvd");
  a_off:         assert property (p_off)         else $error("off");
  a_wake:        assert property (p_wake)        else $error("wake");
  a_fall:        assert property (p_fall)        else $error("fall");
  a_rise_only:   assert property (p_rise_only)   else $error("rise");

  c_capture: cover property (CAPTURE_EVENT);
  c_irq:     cover property (IRQ);
  c_read:    cover property (rd_ok);
endmodule

bind icm_capture icm_capture_properties icm_capture_properties_i (.*);

// ==== sim/icm_src_model.sv ====
// partner model: capture input pin and on-chip event sources
`timescale 1ns/1ps

module icm_src_model (
  input  wire logic        clk,
  input  wire logic        own_cascade,
  output logic             cap_in,
  output logic [31:0]      sync_event,
  output logic             partner_cascade
);
  // the partner channel is programmed alike, so the pair can cascade
  assign partner_cascade = own_cascade;

  initial begin
    cap_in = 1'b0;
    sync_event = 32'h0000_0000;
  end

  // half sets the pulse pace: small is prompt, large is slow
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      @(posedge clk);
      cap_in <= 1'b1;
      repeat (half) @(posedge clk);
      cap_in <= 1'b0;
      repeat (half - 1) @(posedge clk);
    end
  endtask

  // callers never pick the channel's own timer codes, and comparator or
  // converter codes only in trigger use
  task automatic fire(input logic [4:0] code);
    @(posedge clk);
    sync_event[code] <= 1'b1;
    @(posedge clk);
    sync_event <= 32'h0000_0000;
  endtask
endmodule

// ==== sim/tb_top.sv ====
// testbench: register, capture, irq and trigger checks of the channel
`timescale 1ns/1ps

module tb_top;
  logic        clk;
  logic        rst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic        sleep_idle;
  logic [4:0]  timer_tick;
  wire  [31:0] readdata;
  wire         waitreq;
  wire         cap_in;
  wire  [31:0] sync_event;
  wire         partner_cascade;
  wire         cascade_en;
  wire         capture_event;
  wire         irq;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] rd_val;
  int          miscompares;
  int          cmp_count;
  int          cap_cnt;
  int          base;
  logic [4:0]  code;
  // pulses sent and captures expected for modes 000 to 111
  int          pul[8] = '{2, 3, 3, 2, 16, 16, 2, 2};
  int          exc[8] = '{0, 3, 3, 4, 4, 1, 0, 0};

  icm_capture icm_capture_i (
    .CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(readdata),
    .AVS_WAITREQUEST(waitreq), .CAP_IN(cap_in), .SLEEP_IDLE(sleep_idle),
    .TIMER_TICK(timer_tick), .SYNC_EVENT(sync_event),
    .PARTNER_CASCADE(partner_cascade), .CASCADE_EN(cascade_en),
    .TIMER_ROLLOVER(), .CAPTURE_EVENT(capture_event), .IRQ(irq)
  );
  icm_src_model icm_src_model_i (
    .clk(clk), .own_cascade(cascade_en), .cap_in(cap_in),
    .sync_event(sync_event), .partner_cascade(partner_cascade)
  );

  always #2.5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  // one access; a read notes its expected word for the monitor
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    int n;
    @(posedge clk);
    if (!wr) begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    avs_address <= a;
    avs_writedata <= wr ? d : 32'h0000_0000;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    rd_val = readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (waitreq !== 1'b0) begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0000_0000);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    bus(1'b0, a, e, m);
  endtask

  // irq is a function of registers: look one edge after the write
  task automatic chk_irq(input logic e);
    @(posedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  always @(posedge clk) begin
    if (avs_read === 1'b1 && waitreq === 1'b0 && exp_q.size() > 0) begin
      chk("readdata", exp_q[0] & msk_q[0], readdata & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (capture_event === 1'b1) begin
      cap_cnt++;
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    sleep_idle = 1'b0;
    timer_tick = 5'h00;
    void'($urandom(95));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(icm_pkg::OFS_CTRL1, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(icm_pkg::OFS_CTRL2, 32'h0000_000D, 32'hFFFF_FFFF);
    rd(icm_pkg::OFS_IRQ_EN, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(icm_pkg::OFS_IRQ_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(5'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(icm_pkg::OFS_CTRL2, 32'hFFFF_FFFF);
    rd(icm_pkg::OFS_CTRL2, 32'h0000_01DF, 32'hFFFF_FFFF);
    chk("cascade", 32'h1, {31'h0, cascade_en});
    wr(icm_pkg::OFS_CTRL2, 32'h0000_000D);
    rd(icm_pkg::OFS_CTRL2, 32'h0000_000D, 32'hFFFF_FFFF);
    chk("cascade", 32'h0, {31'h0, cascade_en});
    $display("test registers done");

    for (int m = 0; m < 8; m++) begin
      timer_tick <= 5'($urandom);
      sleep_idle <= (m == 7);
      wr(icm_pkg::OFS_CTRL1, 32'(m));
      base = cap_cnt;
      icm_src_model_i.pulses(pul[m], 4);
      repeat (4) @(posedge clk);
      chk("captures", 32'(exc[m]), 32'(cap_cnt - base));
      rd(icm_pkg::OFS_CTRL1, 32'(m) | (exc[m] > 0 ? 32'h8 : 32'h0),
         32'h0000_001F);
      // timer never triggered, so every captured value is zero
      repeat (exc[m]) rd(icm_pkg::OFS_BUF, 32'h0, 32'hFFFF_FFFF);
      rd(icm_pkg::OFS_CTRL1, 32'(m), 32'h0000_001F);
    end
    rd(icm_pkg::OFS_IRQ_STAT, 32'h8, 32'h8);
    sleep_idle <= 1'b0;
    $display("test modes done");

    wr(icm_pkg::OFS_IRQ_CLR, 32'h0000_000F);
    wr(icm_pkg::OFS_CTRL1, 32'h0000_0002);
    icm_src_model_i.pulses(5, 3);
    repeat (4) @(posedge clk);
    rd(icm_pkg::OFS_CTRL1, 32'h0000_001A, 32'h0000_001F);
    rd(icm_pkg::OFS_IRQ_STAT, 32'h0000_0003, 32'h0000_000F);
    chk_irq(1'b0);
    wr(icm_pkg::OFS_IRQ_EN, 32'h0000_0002);
    chk_irq(1'b1);
    wr(icm_pkg::OFS_IRQ_CLR, 32'h0000_0002);
    chk_irq(1'b0);
    wr(icm_pkg::OFS_CTRL1, 32'h0000_0000);
    rd(icm_pkg::OFS_CTRL1, 32'h0000_0000, 32'h0000_0018);
    $display("test overflow done");

    code = 5'($urandom_range(9));
    code = (code < 5'h05) ? code : code + 5'h06;
    wr(icm_pkg::OFS_CTRL1, 32'h0000_1C00);
    wr(icm_pkg::OFS_CTRL2, 32'h80 | 32'(code));
    rd(icm_pkg::OFS_TIMER, 32'h0, 32'hFFFF);
    icm_src_model_i.fire(code);
    rd(icm_pkg::OFS_CTRL2, 32'hC0 | 32'(code), 32'h1FF);
    rd(icm_pkg::OFS_TIMER, 32'h0, 32'h0);
    chk("timer runs", 32'h1, 32'(rd_val[15:0] != 16'h0));
    wr(icm_pkg::OFS_CTRL2, 32'h0000_004B);
    repeat (40) @(posedge clk);
    icm_src_model_i.fire(5'h0B);
    rd(icm_pkg::OFS_TIMER, 32'h0, 32'h0);
    chk("timer resync", 32'h1, 32'(rd_val[15:0] < 16'h0010));
    wr(icm_pkg::OFS_CTRL2, 32'h0000_0085);
    icm_src_model_i.fire(5'h05);
    rd(icm_pkg::OFS_CTRL2, 32'h0000_00C5, 32'h1FF);
    wr(icm_pkg::OFS_CTRL2, 32'h0000_0089);
    icm_src_model_i.fire(5'h09);
    icm_src_model_i.fire(5'h0B);
    rd(icm_pkg::OFS_CTRL2, 32'h0000_0089, 32'h1FF);
    $display("test trigger done");
    wrap_up();
  end
endmodule
